// [shared/rpb_map.svh]
// Address map, field values and timing figures of the relay parameter bank.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef RPB_MAP_SVH
`define RPB_MAP_SVH
`define RPB_A_RECENT 8'h00
`define RPB_A_START0 8'h01
`define RPB_A_TRIP_LO 8'h06
`define RPB_A_TRIP_HI 8'h07
`define RPB_A_DISPLAY 8'h08
`define RPB_A_PEAK 8'h09
`define RPB_A_SET0 8'h0A
`define RPB_A_HIST_LO 8'h10
`define RPB_A_HIST_HI 8'h5F
`define RPB_A_IND_RST 8'h60
`define RPB_A_FULL_RST 8'h61
`define RPB_A_BANK 8'h62
`define RPB_A_MASK_OC 8'h63
`define RPB_A_MASK_RES 8'h64
`define RPB_A_MASK_OA 8'h65
`define RPB_A_MASK_OB 8'h66
`define RPB_A_PW_OPEN 8'h67
`define RPB_A_PW_CHG 8'h68
`define RPB_A_SUP 8'h69
`define RPB_A_FORMAT 8'h6A
`define RPB_A_FAULT 8'h6B
`define RPB_A_NODE 8'h6C
`define RPB_A_BAUD 8'h6D
`define RPB_A_VERSION 8'h6E
`define RPB_A_EV_CMD 8'h70
`define RPB_A_EV_CNT 8'h71
`define RPB_A_EV_LO 8'h72
`define RPB_A_EV_HI 8'h7B
`define RPB_A_STATE 8'h7C
`define RPB_A_TIME 8'h7D
`define RPB_STAGES 5
`define RPB_SLOTS 5
`define RPB_FIELDS 9
`define RPB_EV_DEPTH 65
`define RPB_EV_BATCH 5
`define RPB_CMD_ONE 16'h0001
`define RPB_CMD_REREAD 16'h0002
`define RPB_FORMAT_KEY 16'h0002
`define RPB_OFF_VALUE 16'h03E7
`define RPB_PW_MAX 16'h03E7
`define RPB_PW_RST 10'h001
`define RPB_NODE_MAX 16'h00FE
`define RPB_NODE_RST 8'h01
`define RPB_BAUD_RST 1'b1
`define RPB_MASK_WIDE_MAX 16'h1000
`define RPB_MASK_OA_MAX 16'h00FF
`define RPB_MASK_OB_MAX 16'h03FF
`define RPB_MASK_WIDE_BITS 4'hD
`define RPB_MASK_OA_BITS 4'h8
`define RPB_MASK_OB_BITS 4'hA
`define RPB_BAUD_LO_W 16'h0030
`define RPB_BAUD_HI_W 16'h0060
`define RPB_BAUD_LO_R 16'h12C0
`define RPB_BAUD_HI_R 16'h2580
`define RPB_VERSION 16'h0074
`define RPB_TIME_WRAP 16'hEA5F
`define RPB_ST_NORMAL 16'h0000
`define RPB_ST_AUTORST 16'h0001
`define RPB_ST_OVERFLOW 16'h0002
`define RPB_CLK_PERIOD_NS 25
`define RPB_MS_NS 1000000
`define RPB_WINDOW_MIN 15
`define RPB_MS_PER_MIN 60000
`endif

// [shared/rpb_pkg.sv]
// Types shared by the relay parameter bank and its event store.
// Assumes the map header sits beside it on the include path.
`include "rpb_map.svh"
package rpb_pkg;
  typedef logic [`RPB_FIELDS-1:0][15:0] rpb_rec_t;
  typedef logic [`RPB_STAGES-1:0][15:0] rpb_settings_t;
  typedef struct packed {
    logic [15:0] stamp;
    logic [7:0] channel;
    logic [7:0] code;
  } rpb_evt_t;
endpackage : rpb_pkg

// [hw/rpb_event_store.sv]
// Event store: up to 65 time-stamped events, taken out in batches of up to five.
// Assumes take pulses come from the register side; batch data valid a cycle later.
`timescale 1ns/1ps
`default_nettype none
module rpb_event_store
  import rpb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic push_i,
  input wire rpb_evt_t push_data_i,
  input wire logic take_i,
  input wire logic [2:0] rd_idx_i,
  output rpb_evt_t rd_data_o,
  output logic [2:0] batch_o,
  output logic overflow_o
);
  typedef struct packed {
    logic [6:0] head;
    logic [6:0] count;
    logic [6:0] bbase;
    logic [2:0] bn;
    logic ovf;
  } rpb_es_state_t;

  rpb_es_state_t r, nxt;
  rpb_evt_t mem [0:`RPB_EV_DEPTH-1];
  logic [6:0] tail;
  logic room;

  function automatic logic [6:0] wrap_add(input logic [6:0] a, input logic [6:0] b);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 8'(`RPB_EV_DEPTH))
      s = s - 8'(`RPB_EV_DEPTH);
    return s[6:0];
  endfunction : wrap_add

  // The last batch keeps its slots until the next take so a reread stays intact
  assign room = ({1'b0, r.count} + {5'h00, r.bn}) < 8'(`RPB_EV_DEPTH);
  assign tail = wrap_add(r.head, r.count);

  always_comb begin
    logic [2:0] n;
    n = 3'h0;
    nxt = r;
    nxt.ovf = 1'b0;
    if (take_i) begin
      n = (r.count >= 7'(`RPB_EV_BATCH)) ? 3'(`RPB_EV_BATCH) : r.count[2:0];
      nxt.bbase = r.head;
      nxt.bn = n;
      nxt.head = wrap_add(r.head, {4'h0, n});
    end
    nxt.count = r.count - {4'h0, n};
    if (push_i && room)
      nxt.count = nxt.count + 7'h01;
    if (push_i && !room)
      nxt.ovf = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      r <= '0;
    else
      r <= nxt;
  end

  always_ff @(posedge clk_i) begin
    if (push_i && room)
      mem[tail] <= push_data_i;
  end

  assign rd_data_o = mem[wrap_add(r.bbase, {4'h0, rd_idx_i})];
  assign batch_o = r.bn;
  assign overflow_o = r.ovf;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  batch_size_a: assert property (take_i && r.count >= 7'(`RPB_EV_BATCH)
      |=> batch_o == 3'(`RPB_EV_BATCH))
    else $error("event batch not five with enough events stored");
  store_fill_a: assert property ((r.count + r.bn) <= 7'(`RPB_EV_DEPTH))
    else $error("event store holds more than its depth");
endmodule : rpb_event_store
`default_nettype wire

// [hw/rpb_param_bank.sv]
// Serially addressed parameter bank of an overcurrent and earth-fault relay module.
// Assumes a decoded register port from the link controller, one access per strobe,
// read data valid only in the cycle after the read strobe.
// Operation
// - Stage out of function reads 999 setting
// - Max demand over last 15 minute window
// - Five read-only 8-bit stage start counters
// - Trip cause byte, one weight per stage/phase
// - Readable display operation indication code
// - Keep five recorded current and duration sets
// - Newest in slot n, older shift out
// - Indicator reset clears indicators, releases relay
// - Full reset also clears recorded registers
// - Bank selector: 0 main, 1 second settings
// - Four writable event masks with ranges
// - Password change write replaces password
// - Supervision force lights internal fault indicator
// - Node address 1..254, answer only matching
// - Event read returns time, channel, code
// - Event reread returns previous batch again
// - Module state reads 0, 1 or 2
// - Writing module state clears to normal
// - Millisecond time wraps after 59.999 s
// - Event store holds 65, overflow flagged
// - Each read takes up to five events
`timescale 1ns/1ps
`default_nettype none
`include "rpb_map.svh"
module rpb_param_bank
  import rpb_pkg::*;
#(
  parameter int MS_CYCLES = `RPB_MS_NS / `RPB_CLK_PERIOD_NS,
  parameter int WINDOW_MS = `RPB_WINDOW_MIN * `RPB_MS_PER_MIN
)
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // Register port
  input wire logic [7:0] BUS_NODE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  // Measurements and protection status
  input wire logic [15:0] DEMAND_I,
  input wire logic [`RPB_STAGES-1:0] START_I,
  input wire logic [7:0] TRIP_LO_I,
  input wire logic [2:0] TRIP_HI_I,
  input wire logic [3:0] DISPLAY_CODE_I,
  input wire rpb_settings_t STAGE_SETTING_I,
  input wire logic [`RPB_STAGES-1:0] STAGE_OFF_I,
  input wire logic RECORD_I,
  input wire rpb_rec_t RECORD_DATA_I,
  input wire logic [7:0] FAULT_CODE_I,
  input wire logic AUTO_RESET_I,
  // Events
  input wire logic EVENT_I,
  input wire logic [1:0] EVENT_CHANNEL_I,
  input wire logic [3:0] EVENT_BIT_I,
  // Control outputs
  output logic SETTING_BANK_O,
  output logic INDICATOR_RESET_O,
  output logic INTERNAL_FAULT_INDICATOR_O,
  output logic FORMAT_O,
  output logic [7:0] LINK_NODE_ADDRESS_O,
  output logic LINK_BAUD_9600_O
);
  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] ms_div;
    logic [19:0] win_cnt;
    logic [15:0] win_max;
    logic [15:0] recent;
    logic [15:0] peak;
    logic [`RPB_STAGES-1:0][7:0] starts;
    logic [7:0] trip_lo;
    logic [2:0] trip_hi;
    logic [`RPB_SLOTS-1:0][`RPB_FIELDS*16-1:0] hist;
    logic bank;
    logic [12:0] mask_oc;
    logic [12:0] mask_res;
    logic [7:0] mask_oa;
    logic [9:0] mask_ob;
    logic [9:0] pw;
    logic pw_open;
    logic internal_fault_indicator;
    logic fmt;
    logic ind_rst;
    logic [7:0] node;
    logic baud_hi;
    logic auto_rst;
    logic ovf;
    logic [15:0] time_ms;
  } rpb_state_t;

  rpb_state_t r, nxt;
  logic acc_ok, wr, rd, ms_tick, win_end, full_rst, ev_take, ev_push, ev_ovf, ev_hit;
  logic [2:0] ev_batch;
  logic [3:0] slot;
  rpb_evt_t ev_rd, ev_new;
  logic [15:0] rd_val;

  rpb_event_store u_events (
    .clk_i(CLOCK_I),
    .rstn_i(RESETN_I),
    .push_i(ev_push),
    .push_data_i(ev_new),
    .take_i(ev_take),
    .rd_idx_i(3'(((ADDR_I - `RPB_A_EV_LO) >> 1))),
    .rd_data_o(ev_rd),
    .batch_o(ev_batch),
    .overflow_o(ev_ovf)
  );

  // Frames for another node are dropped without any effect
  assign acc_ok = (BUS_NODE_I == r.node);
  assign wr = WR_I && acc_ok;
  assign rd = RD_I && acc_ok;
  assign ms_tick = (r.ms_div == 16'(MS_CYCLES - 1));
  assign win_end = ms_tick && (r.win_cnt == 20'(WINDOW_MS - 1));
  assign full_rst = wr && (ADDR_I == `RPB_A_FULL_RST) && (WDATA_I == `RPB_CMD_ONE);
  assign ev_take = wr && (ADDR_I == `RPB_A_EV_CMD) && (WDATA_I == `RPB_CMD_ONE);
  assign slot = ADDR_I[7:4] - 4'h1;

  // Masks select which event bits reach the store
  always_comb begin
    case (EVENT_CHANNEL_I)
      2'h0: ev_hit = (EVENT_BIT_I < `RPB_MASK_WIDE_BITS) && r.mask_oc[EVENT_BIT_I];
      2'h1: ev_hit = (EVENT_BIT_I < `RPB_MASK_WIDE_BITS) && r.mask_res[EVENT_BIT_I];
      2'h2: ev_hit = (EVENT_BIT_I < `RPB_MASK_OA_BITS) && r.mask_oa[EVENT_BIT_I[2:0]];
      default: ev_hit = (EVENT_BIT_I < `RPB_MASK_OB_BITS) && r.mask_ob[EVENT_BIT_I];
    endcase
  end
  assign ev_push = EVENT_I && ev_hit;
  assign ev_new = '{stamp: r.time_ms, channel: {6'h00, EVENT_CHANNEL_I} + 8'h01,
                    code: {4'h0, EVENT_BIT_I}};

  // Read multiplexer
  always_comb begin
    rd_val = 16'h0000;
    if (ADDR_I == `RPB_A_RECENT) begin
      rd_val = r.recent;
    end else if (ADDR_I >= `RPB_A_START0 && ADDR_I < `RPB_A_TRIP_LO) begin
      rd_val = {8'h00, r.starts[3'(ADDR_I - `RPB_A_START0)]};
    end else if (ADDR_I == `RPB_A_TRIP_LO) begin
      rd_val = {8'h00, r.trip_lo};
    end else if (ADDR_I == `RPB_A_TRIP_HI) begin
      rd_val = {13'h0000, r.trip_hi};
    end else if (ADDR_I == `RPB_A_DISPLAY) begin
      rd_val = {12'h000, DISPLAY_CODE_I};
    end else if (ADDR_I == `RPB_A_PEAK) begin
      rd_val = r.peak;
    end else if (ADDR_I >= `RPB_A_SET0 && ADDR_I < `RPB_A_SET0 + 8'(`RPB_STAGES)) begin
      rd_val = STAGE_OFF_I[3'(ADDR_I - `RPB_A_SET0)] ? `RPB_OFF_VALUE
               : STAGE_SETTING_I[3'(ADDR_I - `RPB_A_SET0)];
    end else if (ADDR_I >= `RPB_A_HIST_LO && ADDR_I <= `RPB_A_HIST_HI) begin
      if (ADDR_I[3:0] < 4'(`RPB_FIELDS))
        rd_val = r.hist[3'(slot)][ADDR_I[3:0]*16 +: 16];
    end else if (ADDR_I == `RPB_A_BANK) begin
      rd_val = {15'h0000, r.bank};
    end else if (ADDR_I == `RPB_A_MASK_OC) begin
      rd_val = {3'h0, r.mask_oc};
    end else if (ADDR_I == `RPB_A_MASK_RES) begin
      rd_val = {3'h0, r.mask_res};
    end else if (ADDR_I == `RPB_A_MASK_OA) begin
      rd_val = {8'h00, r.mask_oa};
    end else if (ADDR_I == `RPB_A_MASK_OB) begin
      rd_val = {6'h00, r.mask_ob};
    end else if (ADDR_I == `RPB_A_FAULT) begin
      rd_val = {8'h00, FAULT_CODE_I};
    end else if (ADDR_I == `RPB_A_NODE) begin
      rd_val = {8'h00, r.node};
    end else if (ADDR_I == `RPB_A_BAUD) begin
      rd_val = r.baud_hi ? `RPB_BAUD_HI_R : `RPB_BAUD_LO_R;
    end else if (ADDR_I == `RPB_A_VERSION) begin
      rd_val = `RPB_VERSION;
    end else if (ADDR_I == `RPB_A_EV_CNT) begin
      rd_val = {13'h0000, ev_batch};
    end else if (ADDR_I >= `RPB_A_EV_LO && ADDR_I <= `RPB_A_EV_HI) begin
      if (3'(((ADDR_I - `RPB_A_EV_LO) >> 1)) < ev_batch)
        rd_val = ADDR_I[0] ? {ev_rd.channel, ev_rd.code} : ev_rd.stamp;
    end else if (ADDR_I == `RPB_A_STATE) begin
      rd_val = r.ovf ? `RPB_ST_OVERFLOW : (r.auto_rst ? `RPB_ST_AUTORST : `RPB_ST_NORMAL);
    end else if (ADDR_I == `RPB_A_TIME) begin
      rd_val = r.time_ms;
    end
  end

  always_comb begin
    nxt = r;
    nxt.fmt = 1'b0;
    nxt.ind_rst = 1'b0;
    nxt.rdata = rd ? rd_val : 16'h0000;
    // Divider and demand window
    nxt.ms_div = ms_tick ? 16'h0000 : r.ms_div + 16'h0001;
    if (ms_tick) begin
      nxt.time_ms = (r.time_ms == `RPB_TIME_WRAP) ? 16'h0000 : r.time_ms + 16'h0001;
      nxt.win_cnt = win_end ? 20'h00000 : r.win_cnt + 20'h00001;
      if (DEMAND_I > r.win_max)
        nxt.win_max = DEMAND_I;
    end
    if (win_end) begin
      nxt.recent = (DEMAND_I > r.win_max) ? DEMAND_I : r.win_max;
      nxt.win_max = 16'h0000;
      if (nxt.recent > r.peak)
        nxt.peak = nxt.recent;
    end
    // Recordings from the protection side
    for (int k = 0; k < `RPB_STAGES; k++) begin
      if (START_I[k])
        nxt.starts[k] = r.starts[k] + 8'h01;
    end
    nxt.trip_lo = r.trip_lo | TRIP_LO_I;
    nxt.trip_hi = r.trip_hi | TRIP_HI_I;
    if (RECORD_I) begin
      nxt.hist[0] = RECORD_DATA_I;
      for (int k = 1; k < `RPB_SLOTS; k++)
        nxt.hist[k] = r.hist[k-1];
    end
    // Clearing wins over everything of the same cycle except fresh trip flags
    if (full_rst) begin
      nxt.starts = '0;
      nxt.trip_lo = TRIP_LO_I;
      nxt.trip_hi = TRIP_HI_I;
      nxt.hist = '0;
      nxt.recent = 16'h0000;
      nxt.peak = 16'h0000;
      nxt.win_max = 16'h0000;
      nxt.ind_rst = 1'b1;
    end
    if (wr) begin
      if (ADDR_I == `RPB_A_IND_RST && WDATA_I == `RPB_CMD_ONE) begin
        nxt.ind_rst = 1'b1;
      end else if (ADDR_I == `RPB_A_BANK && WDATA_I <= `RPB_CMD_ONE) begin
        nxt.bank = WDATA_I[0];
      end else if (ADDR_I == `RPB_A_MASK_OC && WDATA_I <= `RPB_MASK_WIDE_MAX) begin
        nxt.mask_oc = WDATA_I[12:0];
      end else if (ADDR_I == `RPB_A_MASK_RES && WDATA_I <= `RPB_MASK_WIDE_MAX) begin
        nxt.mask_res = WDATA_I[12:0];
      end else if (ADDR_I == `RPB_A_MASK_OA && WDATA_I <= `RPB_MASK_OA_MAX) begin
        nxt.mask_oa = WDATA_I[7:0];
      end else if (ADDR_I == `RPB_A_MASK_OB && WDATA_I <= `RPB_MASK_OB_MAX) begin
        nxt.mask_ob = WDATA_I[9:0];
      end else if (ADDR_I == `RPB_A_PW_OPEN) begin
        if (WDATA_I == {6'h00, r.pw} && WDATA_I != 16'h0000)
          nxt.pw_open = 1'b1;
      end else if (ADDR_I == `RPB_A_PW_CHG) begin
        if (r.pw_open && WDATA_I <= `RPB_PW_MAX) begin
          nxt.pw = WDATA_I[9:0];
          nxt.pw_open = 1'b0;
        end
      end else if (ADDR_I == `RPB_A_SUP && WDATA_I == `RPB_CMD_ONE) begin
        nxt.internal_fault_indicator = 1'b1;
      end else if (ADDR_I == `RPB_A_FORMAT) begin
        nxt.fmt = r.pw_open && (WDATA_I == `RPB_FORMAT_KEY);
      end else if (ADDR_I == `RPB_A_NODE) begin
        if (WDATA_I != 16'h0000 && WDATA_I <= `RPB_NODE_MAX)
          nxt.node = WDATA_I[7:0];
      end else if (ADDR_I == `RPB_A_BAUD) begin
        if (WDATA_I == `RPB_BAUD_LO_W)
          nxt.baud_hi = 1'b0;
        else if (WDATA_I == `RPB_BAUD_HI_W)
          nxt.baud_hi = 1'b1;
      end else if (ADDR_I == `RPB_A_STATE) begin
        nxt.auto_rst = 1'b0;
        nxt.ovf = 1'b0;
      end else if (ADDR_I == `RPB_A_TIME && WDATA_I <= `RPB_TIME_WRAP) begin
        nxt.time_ms = WDATA_I;
      end
    end
    // A condition arriving with the clear must survive it
    if (AUTO_RESET_I)
      nxt.auto_rst = 1'b1;
    if (ev_ovf)
      nxt.ovf = 1'b1;
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r <= '0;
      r.pw <= `RPB_PW_RST;
      r.node <= `RPB_NODE_RST;
      r.baud_hi <= `RPB_BAUD_RST;
    end else begin
      r <= nxt;
    end
  end

  assign RDATA_O = r.rdata;
  assign SETTING_BANK_O = r.bank;
  assign INDICATOR_RESET_O = r.ind_rst;
  assign INTERNAL_FAULT_INDICATOR_O = r.internal_fault_indicator;
  assign FORMAT_O = r.fmt;
  assign LINK_NODE_ADDRESS_O = r.node;
  assign LINK_BAUD_9600_O = r.baud_hi;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  bank_select_a: assert property (wr && ADDR_I == `RPB_A_BANK && WDATA_I == `RPB_CMD_ONE
      |=> SETTING_BANK_O ##1 SETTING_BANK_O || $past(wr))
    else $error("setting bank did not follow write");
  full_clear_a: assert property (full_rst && TRIP_LO_I == 8'h00
      |=> r.trip_lo == 8'h00 && r.starts == '0 && INDICATOR_RESET_O)
    else $error("full reset left recorded values");
  start_count_a: assert property (START_I[0] && !full_rst
      |=> r.starts[0] == $past(r.starts[0]) + 8'h01)
    else $error("start counter missed a start");
  history_shift_a: assert property (RECORD_I && !full_rst
      |=> r.hist[1] == $past(r.hist[0]) && r.hist[0] == $past(RECORD_DATA_I))
    else $error("history did not shift on recording");
  pw_guard_a: assert property (!r.pw_open |=> $stable(r.pw) && !FORMAT_O)
    else $error("protected write taken without password");
  fault_latch_a: assert property ($rose(INTERNAL_FAULT_INDICATOR_O)
      |-> $past(wr && ADDR_I == `RPB_A_SUP) ##1 INTERNAL_FAULT_INDICATOR_O [*3])
    else $error("internal fault indicator not latched by force write");
  node_range_a: assert property (r.node != 8'h00 && r.node != 8'hFF)
    else $error("node address out of range");
  time_wrap_a: assert property (ms_tick && r.time_ms == `RPB_TIME_WRAP
      && !(wr && ADDR_I == `RPB_A_TIME) |=> r.time_ms == 16'h0000)
    else $error("time did not wrap at end of minute");
  state_set_a: assert property (ev_ovf |=> r.ovf)
    else $error("overflow not flagged");
endmodule : rpb_param_bank
`default_nettype wire

// [tb/rpb_link_master.sv]
// Link-side communicator model: issues register reads and writes on the bank's port.
// Assumes one call at a time from the bench; node_o is set by the bench between calls.
`timescale 1ns/1ps
`default_nettype none
module rpb_link_master (
  // Clock and answer
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  // Request side
  output logic [7:0] node_o = 8'h01,
  output logic [7:0] addr_o = 8'h00,
  output logic [15:0] wdata_o = 16'h0000,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  // Released lines show the inverse so stale values are never mistaken for a request
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(negedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : rpb_link_master
`default_nettype wire

// [tb/rpb_param_bank_tb.sv]
// Self-checking bench for the relay parameter bank with a queue-based reference model.
// Assumes shortened ms tick and demand window; the link model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module rpb_param_bank_tb;
  import rpb_pkg::*;
  localparam int MS = 4;
  localparam int WIN = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] node, addr, node_out;
  logic [15:0] wdata, rdata, d;
  logic wr, rd, bank, ind_rst, internal_fault_indicator, fmt, baud;
  logic [15:0] demand = 16'h0000;
  logic [4:0] start = 5'h00;
  logic [4:0] off = 5'h00;
  logic [7:0] trip_lo = 8'h00;
  logic [7:0] fault = 8'h00;
  logic [2:0] trip_hi = 3'h0;
  logic [3:0] disp = 4'h0;
  logic [3:0] ev_bit = 4'h0;
  logic [1:0] ev_ch = 2'h0;
  rpb_settings_t sett = '0;
  rpb_rec_t rec = '0;
  rpb_rec_t r;
  logic record = 1'b0;
  logic auto_rst = 1'b0;
  logic ev = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  int n_ind = 0;
  int n_fmt = 0;
  int cyc = 0;
  rpb_rec_t hist[$];
  int evq[$];
  int bq[$];
  int n[5];
  int mx[4] = '{4096, 4096, 255, 1023};
  int v, pw;

  rpb_param_bank #(.MS_CYCLES(MS), .WINDOW_MS(WIN)) rpb_param_bank_i (
    .CLOCK_I(clk), .RESETN_I(rstn), .BUS_NODE_I(node), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DEMAND_I(demand), .START_I(start),
    .TRIP_LO_I(trip_lo), .TRIP_HI_I(trip_hi), .DISPLAY_CODE_I(disp), .STAGE_SETTING_I(sett),
    .STAGE_OFF_I(off), .RECORD_I(record), .RECORD_DATA_I(rec), .FAULT_CODE_I(fault),
    .AUTO_RESET_I(auto_rst), .EVENT_I(ev), .EVENT_CHANNEL_I(ev_ch), .EVENT_BIT_I(ev_bit),
    .SETTING_BANK_O(bank), .INDICATOR_RESET_O(ind_rst), .INTERNAL_FAULT_INDICATOR_O(internal_fault_indicator),
    .FORMAT_O(fmt), .LINK_NODE_ADDRESS_O(node_out), .LINK_BAUD_9600_O(baud));

  rpb_link_master rpb_link_master_i (
    .clk_i(clk), .rdata_i(rdata), .node_o(node), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  initial forever #12.5 clk = ~clk;

  // One-cycle pulses are counted here so they cannot slip between two looks
  always @(posedge clk) begin
    if (ind_rst === 1'b1) n_ind++;
    if (fmt === 1'b1) n_fmt++;
    // Store model: stamp is the ms count before this edge; room counts the held batch
    if (ev === 1'b1 && evq.size() + bq.size() < 65)
      evq.push_back(((cyc / MS) << 16) | ((int'(ev_ch) + 1) << 8) | int'(ev_bit));
    if (rstn === 1'b1) cyc++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [15:0] dv);
    rpb_link_master_i.wr(a, dv);
  endtask : w

  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    rpb_link_master_i.rd(a, d);
    chk(d, exp);
  endtask : rc

  task automatic push(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      ev <= 1'b1;
      ev_ch <= 2'(i % 4);
      ev_bit <= 4'(i % 8);
    end
    @(posedge clk);
    ev <= 1'b0;
    // Let the model take the last event before anyone looks at the queue
    @(negedge clk);
  endtask : push

  task automatic take(input logic [15:0] cmd);
    if (cmd == 16'h0001) begin
      bq = {};
      while (evq.size() > 0 && bq.size() < 5) bq.push_back(evq.pop_front());
    end
    w(8'h70, cmd);
    rc(8'h71, 16'(bq.size()));
    for (int i = 0; i < 5; i++) begin
      rc(8'h72 + 8'(2 * i), i < bq.size() ? 16'(bq[i] >> 16) : 16'h0000);
      rc(8'h73 + 8'(2 * i), i < bq.size() ? 16'(bq[i]) : 16'h0000);
    end
  endtask : take

  task automatic report_and_stop;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    v = $urandom(32'hF97C);
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rc(8'h6D, 16'h2580);
    rc(8'h7C, 16'h0000);
    rc(8'h0F, 16'h0000);
    for (int b = 1; b >= 0; b--) begin
      w(8'h62, 16'(b));
      chk(16'(bank), 16'(b));
      rc(8'h62, 16'(b));
    end
    for (int j = 0; j < 4; j++) begin
      v = $urandom % (mx[j] + 1);
      w(8'h63 + 8'(j), 16'(v));
      w(8'h63 + 8'(j), 16'(mx[j] + 1));
      rc(8'h63 + 8'(j), 16'(v));
    end
    // Change while closed must be refused, so the new value cannot open yet
    pw = 2 + $urandom % 998;
    w(8'h6A, 16'h0002);
    w(8'h68, 16'(pw));
    w(8'h67, 16'(pw));
    w(8'h6A, 16'h0002);
    w(8'h67, 16'h0001);
    w(8'h68, 16'(pw));
    w(8'h6A, 16'h0002);
    w(8'h67, 16'h0001);
    w(8'h6A, 16'h0002);
    w(8'h67, 16'(pw));
    w(8'h6A, 16'h0002);
    chk(16'(internal_fault_indicator), 16'h0000);
    w(8'h69, 16'h0001);
    chk(16'(internal_fault_indicator), 16'h0001);
    chk(16'(n_fmt), 16'h0001);
    w(8'h6C, 16'h00FF);
    rc(8'h6C, 16'h0001);
    w(8'h6C, 16'h0005);
    chk(16'(node_out), 16'h0005);
    rc(8'h6C, 16'h0000);
    @(posedge clk);
    rpb_link_master_i.node_o <= 8'h05;
    rc(8'h6C, 16'h0005);
    w(8'h6D, 16'h0030);
    chk(16'(baud), 16'h0000);
    rc(8'h6D, 16'h12C0);
    w(8'h6D, 16'h0060);
    rc(8'h6D, 16'h2580);
    v = $urandom;
    @(posedge clk);
    demand <= v[15:0];
    fault <= v[23:16];
    trip_lo <= v[31:24];
    trip_hi <= 3'h5;
    disp <= 4'hC;
    off <= 5'h15;
    sett <= 80'({$urandom, $urandom, $urandom});
    @(posedge clk);
    trip_lo <= 8'h00;
    trip_hi <= 3'h0;
    repeat (3 * MS * WIN) @(posedge clk);
    rc(8'h00, v[15:0]);
    rc(8'h09, v[15:0]);
    rc(8'h06, {8'h00, v[31:24]});
    rc(8'h07, 16'h0005);
    rc(8'h08, 16'h000C);
    rc(8'h6B, {8'h00, v[23:16]});
    for (int k = 0; k < 5; k++)
      rc(8'h0A + 8'(k), off[k] ? 16'h03E7 : sett[k]);
    for (int k = 0; k < 5; k++) n[k] = $urandom % 300;
    for (int c = 0; c < 300; c++) begin
      @(posedge clk);
      for (int k = 0; k < 5; k++) start[k] <= (c < n[k]);
    end
    @(posedge clk);
    start <= 5'h00;
    for (int k = 0; k < 5; k++)
      rc(8'h01 + 8'(k), 16'(n[k] % 256));
    repeat (6) begin
      r = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
      hist.push_front(r);
      @(posedge clk);
      rec <= r;
      record <= 1'b1;
      @(posedge clk);
      record <= 1'b0;
    end
    hist = hist[0:4];
    for (int s = 0; s < 5; s++)
      for (int f = 0; f < 9; f++)
        rc(8'h10 + 8'(16 * s + f), hist[s][f]);
    w(8'h60, 16'h0001);
    rc(8'h10, hist[0][0]);
    rc(8'h06, {8'h00, v[31:24]});
    chk(16'(n_ind), 16'h0001);
    w(8'h61, 16'h0001);
    rc(8'h10, 16'h0000);
    rc(8'h06, 16'h0000);
    chk(16'(n_ind), 16'h0002);
    for (int j = 0; j < 4; j++)
      w(8'h63 + 8'(j), 16'(j < 2 ? mx[j] - 1 : mx[j]));
    push(7);
    take(16'h0001);
    take(16'h0002);
    take(16'h0001);
    take(16'h0001);
    push(66);
    rc(8'h7C, 16'h0002);
    take(16'h0001);
    w(8'h7C, 16'h0000);
    rc(8'h7C, 16'h0000);
    @(posedge clk);
    auto_rst <= 1'b1;
    @(posedge clk);
    auto_rst <= 1'b0;
    rc(8'h7C, 16'h0001);
    w(8'h7C, 16'h0000);
    rc(8'h7C, 16'h0000);
    w(8'h7D, 16'hEA5F);
    rpb_link_master_i.rd(8'h7D, d);
    chk(16'(d == 16'hEA5F || d == 16'h0000), 16'h0001);
    w(8'h7D, 16'hEA60);
    rpb_link_master_i.rd(8'h7D, d);
    chk(16'(d < 16'h0010), 16'h0001);
    report_and_stop();
  end
endmodule : rpb_param_bank_tb
`default_nettype wire
